// ===== adc_cal_params.svh
// Constants of the calibration datapath: widths, limits, register map.
// Assumes inclusion by bare name from the package and design modules.
`ifndef ADC_CAL_PARAMS_SVH
`define ADC_CAL_PARAMS_SVH

// Data widths and signed limits
`define RAW_W 19
`define RAW_MAX 19'h3FFFF
`define RAW_MIN 19'h40000
`define OC_MAX 17'h0FFFF
`define OC_MIN 17'h10000
`define SC_MIN 18'h02000
`define SC_MAX 18'h3FFFF
`define RES_MAX 16'h7FFF
`define RES_MIN 16'h8000
`define RES_MIN_MAG 18'h08000
`define RES_MAX_MAG 18'h07FFF
`define MAIN_SHIFT 14
`define AUX_SHIFT 16
`define AUX_HALF 34'h000008000
`define AREA1_BOUND 8'hD3

// Register byte addresses
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_GAIN 8'h08
`define REG_MAIN 8'h0C
`define REG_AUX 8'h10
`define REG_OFF_BOUND 8'h14
`define REG_GAIN_BOUND 8'h18
`define REG_RAW 8'h1C
`define REG_OFF_SLOPE 8'h20
`define REG_OFF_ICPT 8'h30
`define REG_GAIN_SLOPE 8'h40
`define REG_GAIN_ICPT 8'h50
`define REG_AUX_OFF 8'h60
`define REG_AUX_GAIN 8'h64

// Control fields
`define CTRL_PRE_EN 0
`define CTRL_PRE_GAIN_LO 1
`define CTRL_ADC_GAIN_LO 3

// Status fields
`define ST_COEF_ERR 0
`define ST_SUM_ERR 1
`define ST_CLIP 2
`define ST_READY_N 3
`define ST_BUSY 4

`endif

// ===== adc_cal_pkg.sv
// Types shared by the calibration datapath modules.
// Assumes adc_cal_params.svh is on the include path.
`include "adc_cal_params.svh"

package adc_cal_pkg;

	// One piecewise-linear coefficient table: three boundaries, four areas
	typedef struct packed {
		logic [2:0][7:0] bound;
		logic [3:0][15:0] slope;
		logic [3:0][15:0] icpt;
	} coef_set_t;

	typedef struct packed {
		logic clip;
		logic sum_err;
		logic coef_err;
	} cal_flags_t;

	typedef enum logic [2:0] {
		S_IDLE,
		S_COEF,
		S_DIV,
		S_DONE,
		S_REPORT
	} cal_state_t;

endpackage

// ===== coef_segment.sv
// Piecewise-linear temperature coefficient, four areas.
// Assumes the three boundaries are programmed in ascending order.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_params.svh"

module coef_segment import adc_cal_pkg::*; #(
	parameter bit ICPT_SIGNED = 1'b1,
	parameter int OUT_W = 30
) (
	// Temperature, signed quarter degrees
	input wire logic [9:0] temp_code,
	// Table
	input wire coef_set_t coef_set,
	// Result, full width before range checks
	output logic signed [OUT_W-1:0] coef
);

	logic signed [7:0] t_deg;
	logic [1:0] area;
	logic [7:0] low_bound;
	logic signed [10:0] diff;
	logic signed [26:0] prod;
	logic [15:0] icpt;

	assign t_deg = $signed(temp_code[9:2]);

	always_comb begin // RULE5
		if (t_deg < $signed(coef_set.bound[0])) begin
			area = 2'd0;
		end else if (t_deg < $signed(coef_set.bound[1])) begin
			area = 2'd1;
		end else if (t_deg < $signed(coef_set.bound[2])) begin
			area = 2'd2;
		end else begin
			area = 2'd3;
		end
	end

	always_comb begin
		if (area == 2'd0) begin
			low_bound = `AREA1_BOUND;
		end else begin
			low_bound = coef_set.bound[area - 2'd1];
		end
		icpt = coef_set.icpt[area];
		diff = $signed({temp_code[9], temp_code})
			- $signed({low_bound[7], low_bound, 2'b00});
		prod = diff * $signed(coef_set.slope[area]);
		if (ICPT_SIGNED) begin
			coef = OUT_W'(prod) + OUT_W'($signed({icpt, 2'b00}));
		end else begin
			coef = OUT_W'(prod) + OUT_W'($signed({1'b0, icpt, 2'b00}));
		end
	end

endmodule

`default_nettype wire

// ===== adc_data_calibration.sv
// Calibration datapath from decimator result to two 16-bit results.
// Assumes a one-cycle sample strobe and a plain register port.
//
// Functional notes
// [RULE1] Raw result is signed 19-bit two's complement
// [RULE2] Preamp gain 1 unless enabled, then 1/2/4/8
// [RULE3] Converter gain code selects 1/2/4/8
// [RULE4] Raw result clamped to signed 19-bit range
// [RULE5] Temperature bits 9..2 pick one of four areas
// [RULE6] Offset coef: slope times distance plus intercept
// [RULE7] Offset coef out of 17 bits: coefficient error
// [RULE8] Offset sum is raw plus four offset coef
// [RULE9] Offset sum beyond 19 bits: sum error
// [RULE10] Sensitivity coef uses same four-area form
// [RULE11] Sensitivity outside 8192..262143: coefficient error
// [RULE12] Main result is sum times 2^14 over sensitivity
// [RULE13] Main result clipped to 16 bits, flag set
// [RULE14] Sensitivity read as 2.16 fixed point gain (the code divides by it as 4.14, with 2^14 as unity)
// [RULE15] Second channel drops two bits, subtracts offset
// [RULE16] Second offset value beyond 17 bits: sum error
// [RULE17] Second result is value times gain over 2^16
// [RULE18] Second result clipped to 16 bits, flag set
// [RULE19] Temperature code signed 10-bit, quarter degrees
// [RULE20] Result written first, then ready goes low
// [RULE21] Round halves away from zero; flags sticky
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_params.svh"

module adc_data_calibration import adc_cal_pkg::*; #(
	parameter int RAW_IN_W = 24,
	parameter int DIV_W = 34
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Decimator side
	input wire logic signed [RAW_IN_W-1:0] filter_in,
	input wire logic filter_valid,
	input wire logic second_sel,
	input wire logic [9:0] temperature_code,
	// Status and results
	output logic calib_busy,
	output logic result_ready_n,
	output logic [15:0] main_channel_result,
	output logic [15:0] second_channel_result
);

	localparam logic signed [RAW_IN_W-1:0] RAW_HI =
		{{(RAW_IN_W-`RAW_W){1'b0}}, `RAW_MAX};
	localparam logic signed [RAW_IN_W-1:0] RAW_LO =
		{{(RAW_IN_W-`RAW_W){1'b1}}, `RAW_MIN};
	localparam logic [5:0] DIV_STEPS = 6'(DIV_W);

	////////////////////////////////////////////////////////////////////
	// Registers

	cal_state_t state_r;
	logic [4:0] ctrl_r;
	coef_set_t off_set_r;
	coef_set_t gain_set_r;
	logic [16:0] second_offset_coef_r;
	logic [16:0] second_gain_coef_r;
	cal_flags_t flags_r;
	logic result_ready_n_r;
	logic [15:0] main_r;
	logic [15:0] second_r;
	logic [18:0] filter_raw_result_r;
	logic [9:0] temp_r;
	logic sel_r;
	logic [16:0] d1_r;
	logic [19:0] div_rem_r;
	logic [DIV_W-1:0] div_quo_r;
	logic [18:0] div_den_r;
	logic div_neg_r;
	logic [5:0] div_cnt_r;

	logic [1:0] pre_gain_code;
	logic [1:0] adc_gain_code;
	logic preamp_enable;
	logic [3:0] pre_gain;
	logic [3:0] adc_gain;
	logic [6:0] total_gain;

	logic signed [29:0] oc_full;
	logic signed [29:0] sc_full;
	logic oc_bad;
	logic sc_bad;
	logic signed [20:0] sum_full;
	logic sum_bad;
	logic signed [17:0] d1_full;
	logic d1_bad;
	logic [18:0] sum_mag;
	logic [DIV_W-1:0] div_num;
	logic [19:0] trial;
	logic div_bit;
	logic [15:0] main_clip_val;
	logic main_clip;
	logic signed [34:0] aux_prod;
	logic [33:0] aux_mag;
	logic [17:0] aux_rnd;
	logic [15:0] aux_clip_val;
	logic aux_clip;
	logic sample_take;
	logic [1:0] reg_idx;

	assign sample_take = filter_valid && (state_r == S_IDLE);
	assign reg_idx = reg_addr[3:2];

	////////////////////////////////////////////////////////////////////
	// Gain decode

	assign preamp_enable = ctrl_r[`CTRL_PRE_EN];
	assign pre_gain_code = ctrl_r[`CTRL_PRE_GAIN_LO +: 2];
	assign adc_gain_code = ctrl_r[`CTRL_ADC_GAIN_LO +: 2];

	always_comb begin
		pre_gain = 4'h1;
		if (preamp_enable) begin
			pre_gain = 4'h1 << pre_gain_code; // RULE2
		end
		adc_gain = 4'h1 << adc_gain_code; // RULE3
		total_gain = 7'(pre_gain * adc_gain);
	end

	////////////////////////////////////////////////////////////////////
	// Coefficients and offset sums

	coef_segment #(
		.ICPT_SIGNED(1'b1),
		.OUT_W(30)
	) u_offset_coef (
		.temp_code(temp_r),
		.coef_set(off_set_r),
		.coef(oc_full)
	); // RULE6

	coef_segment #(
		.ICPT_SIGNED(1'b0),
		.OUT_W(30)
	) u_sens_coef (
		.temp_code(temp_r),
		.coef_set(gain_set_r),
		.coef(sc_full)
	); // RULE10

	always_comb begin
		oc_bad = (oc_full > $signed({13'h0000, `OC_MAX}))
			|| (oc_full < $signed({13'h1FFF, `OC_MIN})); // RULE7
		sc_bad = (sc_full < $signed({12'h000, `SC_MIN}))
			|| (sc_full > $signed({12'h000, `SC_MAX})); // RULE11 RULE14
		sum_full = 21'($signed(filter_raw_result_r))
			+ 21'($signed({oc_full[16:0], 2'b00})); // RULE8
		sum_bad = (sum_full > $signed({2'b00, `RAW_MAX}))
			|| (sum_full < $signed({2'b11, `RAW_MIN})); // RULE9
		d1_full = 18'($signed(filter_raw_result_r[18:2]))
			- 18'($signed(second_offset_coef_r)); // RULE15
		d1_bad = (d1_full > $signed({1'b0, `OC_MAX}))
			|| (d1_full < $signed({1'b1, `OC_MIN})); // RULE16
	end

	////////////////////////////////////////////////////////////////////
	// Division and rounding

	always_comb begin
		sum_mag = sum_full[18] ? 19'(-sum_full[18:0]) : sum_full[18:0];
		// Magnitude * 2^15 + SC, over 2 * SC: half rounds away from zero
		div_num = DIV_W'({sum_mag, {(`MAIN_SHIFT + 1){1'b0}}})
			+ DIV_W'(sc_full[17:0]); // RULE12 RULE21
		trial = {div_rem_r[18:0], div_quo_r[DIV_W-1]};
		div_bit = (trial >= {1'b0, div_den_r});
		if (div_neg_r) begin
			main_clip = (div_quo_r > DIV_W'(`RES_MIN_MAG));
			main_clip_val = main_clip ? `RES_MIN
				: 16'(-div_quo_r[15:0]);
		end else begin
			main_clip = (div_quo_r > DIV_W'(`RES_MAX_MAG));
			main_clip_val = main_clip ? `RES_MAX : div_quo_r[15:0];
		end // RULE13
	end

	always_comb begin
		aux_prod = 35'($signed(d1_r))
			* $signed({1'b0, second_gain_coef_r}); // RULE17
		aux_mag = aux_prod[34] ? 34'(-aux_prod) : aux_prod[33:0];
		aux_rnd = 18'((aux_mag + `AUX_HALF) >> `AUX_SHIFT); // RULE21
		if (aux_prod[34]) begin
			aux_clip = (aux_rnd > `RES_MIN_MAG);
			aux_clip_val = aux_clip ? `RES_MIN : 16'(-aux_rnd[15:0]);
		end else begin
			aux_clip = (aux_rnd > `RES_MAX_MAG);
			aux_clip_val = aux_clip ? `RES_MAX : aux_rnd[15:0];
		end // RULE18
	end

	////////////////////////////////////////////////////////////////////
	// Sequencer

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_r <= S_IDLE;
		end else begin
			unique case (state_r)
				S_IDLE: begin
					if (filter_valid) begin
						state_r <= S_COEF;
					end
				end
				S_COEF: begin
					state_r <= sel_r ? S_DONE : S_DIV;
				end
				S_DIV: begin
					if (div_cnt_r == DIV_STEPS) begin
						state_r <= S_DONE;
					end
				end
				S_DONE: begin
					state_r <= S_REPORT;
				end
				S_REPORT: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	// Input capture
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			filter_raw_result_r <= '0;
			temp_r <= '0;
			sel_r <= 1'b0;
		end else if (sample_take) begin
			if (filter_in > RAW_HI) begin
				filter_raw_result_r <= `RAW_MAX; // RULE4
			end else if (filter_in < RAW_LO) begin
				filter_raw_result_r <= `RAW_MIN; // RULE4
			end else begin
				filter_raw_result_r <= filter_in[18:0]; // RULE1
			end
			temp_r <= temperature_code; // RULE19 RULE5
			sel_r <= second_sel;
		end
	end

	// Operands for the later stages
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			d1_r <= '0;
		end else if (state_r == S_COEF) begin
			d1_r <= d1_full[16:0];
		end
	end

	// Restoring divider, one quotient bit a cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			div_rem_r <= '0;
			div_quo_r <= '0;
			div_den_r <= '0;
			div_neg_r <= 1'b0;
			div_cnt_r <= '0;
		end else if (state_r == S_COEF) begin
			div_rem_r <= '0;
			div_quo_r <= div_num;
			div_cnt_r <= '0;
			div_neg_r <= sum_full[18];
			div_den_r <= {sc_full[17:0], 1'b0};
		end else if (state_r == S_DIV) begin
			// One step per quotient bit, all DIV_W of them
			if (div_cnt_r != DIV_STEPS) begin
				div_rem_r <= div_bit ? (trial - {1'b0, div_den_r})
					: trial;
				div_quo_r <= {div_quo_r[DIV_W-2:0], div_bit};
				div_cnt_r <= div_cnt_r + 6'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Results, ready and flags

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			main_r <= '0;
			second_r <= '0;
		end else if (state_r == S_DONE) begin
			if (sel_r) begin
				second_r <= aux_clip_val; // RULE18
			end else begin
				main_r <= main_clip_val; // RULE13
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			result_ready_n_r <= 1'b1;
		end else if (sample_take) begin
			result_ready_n_r <= 1'b1;
		end else if (state_r == S_REPORT) begin
			result_ready_n_r <= 1'b0; // RULE20
		end
	end

	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			flags_r <= '0;
		end else begin
			if (reg_wr && reg_addr == `REG_STATUS) begin
				flags_r.coef_err <= flags_r.coef_err
					& ~reg_wdata[`ST_COEF_ERR];
				flags_r.sum_err <= flags_r.sum_err
					& ~reg_wdata[`ST_SUM_ERR];
				flags_r.clip <= flags_r.clip & ~reg_wdata[`ST_CLIP];
			end
			if (state_r == S_COEF && !sel_r && (oc_bad || sc_bad)) begin
				flags_r.coef_err <= 1'b1; // RULE7 RULE11 RULE21
			end
			if (state_r == S_COEF && (sel_r ? d1_bad : sum_bad)) begin
				flags_r.sum_err <= 1'b1; // RULE9 RULE16 RULE21
			end
			if (state_r == S_DONE && (sel_r ? aux_clip : main_clip)) begin
				flags_r.clip <= 1'b1; // RULE13 RULE18 RULE21
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register writes

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ctrl_r <= '0;
			off_set_r <= '0;
			gain_set_r <= '0;
			second_offset_coef_r <= '0;
			second_gain_coef_r <= '0;
		end else if (reg_wr) begin
			unique case (reg_addr[7:4])
				4'h0: begin
					if (reg_addr == `REG_CTRL) begin
						ctrl_r <= reg_wdata[4:0];
					end
				end
				4'h1: begin
					if (reg_addr == `REG_OFF_BOUND) begin
						off_set_r.bound <= reg_wdata[23:0];
					end
					if (reg_addr == `REG_GAIN_BOUND) begin
						gain_set_r.bound <= reg_wdata[23:0];
					end
				end
				4'h2: off_set_r.slope[reg_idx] <= reg_wdata[15:0];
				4'h3: off_set_r.icpt[reg_idx] <= reg_wdata[15:0];
				4'h4: gain_set_r.slope[reg_idx] <= reg_wdata[15:0];
				4'h5: gain_set_r.icpt[reg_idx] <= reg_wdata[15:0];
				4'h6: begin
					if (reg_addr == `REG_AUX_OFF) begin
						second_offset_coef_r <= reg_wdata[16:0];
					end
					if (reg_addr == `REG_AUX_GAIN) begin
						second_gain_coef_r <= reg_wdata[16:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register reads, data valid only in the cycle after the strobe

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			reg_rdata <= '0;
		end else if (!reg_rd) begin
			reg_rdata <= '0;
		end else begin
			unique case (reg_addr[7:4])
				4'h0: begin
					unique case (reg_addr)
						`REG_CTRL: reg_rdata <= {27'h0, ctrl_r};
						`REG_STATUS: reg_rdata <= {27'h0,
							(state_r != S_IDLE), result_ready_n_r,
							flags_r.clip, flags_r.sum_err,
							flags_r.coef_err};
						`REG_GAIN: reg_rdata <= {25'h0, total_gain};
						`REG_MAIN: reg_rdata <= {16'h0, main_r};
						default: reg_rdata <= '0;
					endcase
				end
				4'h1: begin
					unique case (reg_addr)
						`REG_AUX: reg_rdata <= {16'h0, second_r};
						`REG_OFF_BOUND:
							reg_rdata <= {8'h0, off_set_r.bound};
						`REG_GAIN_BOUND:
							reg_rdata <= {8'h0, gain_set_r.bound};
						`REG_RAW:
							reg_rdata <= {13'h0, filter_raw_result_r};
						default: reg_rdata <= '0;
					endcase
				end
				4'h2: reg_rdata <= {16'h0, off_set_r.slope[reg_idx]};
				4'h3: reg_rdata <= {16'h0, off_set_r.icpt[reg_idx]};
				4'h4: reg_rdata <= {16'h0, gain_set_r.slope[reg_idx]};
				4'h5: reg_rdata <= {16'h0, gain_set_r.icpt[reg_idx]};
				4'h6: begin
					if (reg_addr == `REG_AUX_OFF) begin
						reg_rdata <= {15'h0, second_offset_coef_r};
					end else if (reg_addr == `REG_AUX_GAIN) begin
						reg_rdata <= {15'h0, second_gain_coef_r};
					end else begin
						reg_rdata <= '0;
					end
				end
				default: reg_rdata <= '0;
			endcase
		end
	end

	assign calib_busy = (state_r != S_IDLE);
	assign result_ready_n = result_ready_n_r;
	assign main_channel_result = main_r;
	assign second_channel_result = second_r;

endmodule

`default_nettype wire

// ===== adc_cal_chk.sv
// Port checker for the calibration datapath.
// Assumes it is bound onto the top module; one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_params.svh"

module adc_cal_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Sample side
	input wire logic filter_valid,
	input wire logic second_sel,
	input wire logic calib_busy,
	input wire logic result_ready_n,
	input wire logic [15:0] main_channel_result,
	input wire logic [15:0] second_channel_result
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	logic take;
	assign take = filter_valid && !calib_busy;
	////////////////////////////////////////////////////////////
	sequence s_main_work;
		calib_busy [*8] ##30 calib_busy;
	endsequence
	sequence s_ready;
		!calib_busy && !result_ready_n;
	endsequence
	property p_main_lat;
		take && !second_sel |=> s_main_work ##1 s_ready;
	endproperty
	a_main_lat: assert property (p_main_lat)
		else $error("main latency off");
	property p_sec_lat;
		take && second_sel |=> calib_busy ##2 calib_busy ##1 s_ready;
	endproperty
	a_sec_lat: assert property (p_sec_lat)
		else $error("second latency off");
	property p_ready_rise;
		take |=> result_ready_n;
	endproperty
	a_ready_rise: assert property (p_ready_rise)
		else $error("ready not withdrawn");
	property p_ready_hold;
		!result_ready_n && !take |=> !result_ready_n;
	endproperty
	a_ready_hold: assert property (p_ready_hold)
		else $error("ready dropped early");
	property p_ready_fall;
		$fell(result_ready_n) |-> $past(calib_busy) && !calib_busy;
	endproperty
	a_ready_fall: assert property (p_ready_fall)
		else $error("ready before work ends");
	property p_main_quiet;
		!$stable(main_channel_result) |-> calib_busy;
	endproperty
	a_main_quiet: assert property (p_main_quiet)
		else $error("main result moved while idle");
	property p_sec_quiet;
		!$stable(second_channel_result) |-> calib_busy;
	endproperty
	a_sec_quiet: assert property (p_sec_quiet)
		else $error("second result moved while idle");
	property p_rd_main;
		reg_rd && reg_addr == `REG_MAIN
			|=> reg_rdata == {16'h0000, $past(main_channel_result)};
	endproperty
	a_rd_main: assert property (p_rd_main)
		else $error("main read mismatch");
	property p_rd_sec;
		reg_rd && reg_addr == `REG_AUX
			|=> reg_rdata == {16'h0000, $past(second_channel_result)};
	endproperty
	a_rd_sec: assert property (p_rd_sec)
		else $error("second read mismatch");
	property p_rd_ready;
		reg_rd && reg_addr == `REG_STATUS
			|=> reg_rdata[`ST_READY_N] == $past(result_ready_n);
	endproperty
	a_rd_ready: assert property (p_rd_ready)
		else $error("status ready bit mismatch");
endmodule

bind adc_data_calibration adc_cal_chk u_chk (
	.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .filter_valid(filter_valid),
	.second_sel(second_sel), .calib_busy(calib_busy),
	.result_ready_n(result_ready_n),
	.main_channel_result(main_channel_result),
	.second_channel_result(second_channel_result)
);
`default_nettype wire

// ===== decim_model.sv
// Behavioural decimator feeding one sample per request.
// Assumes go is a one-cycle pulse; lag delays the strobe.
`timescale 1ns/1ps
`default_nettype none

module decim_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Bench request
	input wire logic go,
	input wire logic [3:0] lag,
	input wire logic [23:0] raw,
	input wire logic sel,
	input wire logic [9:0] temp,
	// Block side
	input wire logic calib_busy,
	output logic [23:0] filter_in = 24'h000000,
	output logic filter_valid = 1'b0,
	output logic second_sel = 1'b0,
	output logic [9:0] temperature_code = 10'h000
);
	logic pend_r = 1'b0;
	logic [3:0] wait_r = 4'h0;
	// Outside the strobe the lines carry inverted junk
	always @(posedge clk_sys) begin
		filter_valid <= 1'b0;
		filter_in <= ~filter_in;
		second_sel <= ~second_sel;
		temperature_code <= ~temperature_code;
		if (!rst_b) begin
			pend_r <= 1'b0;
			wait_r <= 4'h0;
		end else if (go) begin
			pend_r <= 1'b1;
			wait_r <= lag;
		end else if (wait_r != 4'h0) begin
			wait_r <= wait_r - 4'h1;
		end else if (pend_r && !calib_busy) begin
			pend_r <= 1'b0;
			filter_valid <= 1'b1;
			filter_in <= raw;
			second_sel <= sel;
			temperature_code <= temp;
		end
	end
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the calibration datapath.
// Assumes the decimator model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_params.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %s expected %h seen %h", nm, e, g); end end

module tb;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [23:0] filter_in;
	logic filter_valid;
	logic second_sel;
	logic [9:0] temperature_code;
	logic calib_busy;
	logic result_ready_n;
	logic [15:0] main_channel_result;
	logic [15:0] second_channel_result;
	logic go = 1'b0;
	logic [3:0] lag = 4'h0;
	logic [23:0] raw = 24'h0;
	logic sel = 1'b0;
	logic [9:0] temp = 10'h0;
	logic [31:0] rdv;
	int n_errors = 0;
	int checks = 0;

	adc_data_calibration #(.RAW_IN_W(24), .DIV_W(34)) dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .filter_in(filter_in),
		.filter_valid(filter_valid), .second_sel(second_sel),
		.temperature_code(temperature_code), .calib_busy(calib_busy),
		.result_ready_n(result_ready_n),
		.main_channel_result(main_channel_result),
		.second_channel_result(second_channel_result));
	decim_model u_model (
		.clk_sys(clk_sys), .rst_b(rst_b), .go(go), .lag(lag), .raw(raw),
		.sel(sel), .temp(temp), .calib_busy(calib_busy),
		.filter_in(filter_in), .filter_valid(filter_valid),
		.second_sel(second_sel), .temperature_code(temperature_code));

	always #25 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rdv = reg_rdata;
	endtask
	task automatic setall(input logic [7:0] base, input logic [31:0] v);
		for (int n = 0; n < 4; n++) begin
			wr(8'(base + 4 * n), v);
		end
	endtask
	task automatic samp(input logic [23:0] r, input logic s,
			input logic [9:0] t);
		int k;
		@(posedge clk_sys);
		raw <= r;
		sel <= s;
		temp <= t;
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		#1;
		for (k = 0; k < 20 && calib_busy !== 1'b1; k++) begin
			@(posedge clk_sys);
			#1;
		end
		for (k = 0; k < 60 && result_ready_n !== 1'b0; k++) begin
			@(posedge clk_sys);
			#1;
		end
		`CHK("ready", 1'b0, result_ready_n)
	endtask
	task automatic fl(input logic [2:0] e, input logic [2:0] m);
		rd(`REG_STATUS);
		`CHK("flags", e, rdv[2:0] & m)
		wr(`REG_STATUS, 32'h7);
	endtask
	task automatic mcase(input logic [23:0] r, input logic [9:0] t,
			input logic [15:0] e, input logic [2:0] f);
		samp(r, 1'b0, t);
		rd(`REG_MAIN);
		`CHK("main", {16'h0, e}, rdv)
		fl(f, 3'b111);
	endtask
	task automatic scase(input logic [23:0] r, input logic [15:0] e,
			input logic [2:0] f);
		samp(r, 1'b1, 10'h000);
		rd(`REG_AUX);
		`CHK("second", {16'h0, e}, rdv)
		fl(f, 3'b111);
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_reset();
		rst_b <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		wr(`REG_MAIN, 32'h0000FFFF);
		rd(`REG_MAIN);
		`CHK("main", 32'h0, rdv)
		rd(`REG_STATUS);
		`CHK("status", 32'h00000008, rdv)
		rd(8'h7C);
		`CHK("unmapped", 32'h0, rdv)
	endtask
	task automatic t_gain();
		for (int c = 0; c < 32; c++) begin
			wr(`REG_CTRL, 32'(c));
			rd(`REG_GAIN);
			`CHK("gain", 32'((c[0] ? 1 << c[2:1] : 1) << c[4:3]), rdv)
		end
	endtask
	task automatic t_clamp();
		samp(24'h100000, 1'b1, 10'h000);
		rd(`REG_RAW);
		`CHK("raw", 32'h0003FFFF, rdv)
		samp(24'hF00000, 1'b1, 10'h000);
		rd(`REG_RAW);
		`CHK("raw", 32'h00040000, rdv)
		samp(24'hFFFFFF, 1'b1, 10'h000);
		rd(`REG_RAW);
		`CHK("raw", 32'h0007FFFF, rdv)
	endtask
	task automatic t_area();
		logic [9:0] tc [5] = '{10'h3FC, 10'h003, 10'h04F, 10'h050, 10'h190};
		logic [15:0] ex [5] = '{16'h06B8, 16'h0414, 16'h0544, 16'h0418,
			16'h06A8};
		wr(`REG_OFF_BOUND, 32'h003C1400);
		wr(`REG_GAIN_BOUND, 32'h003C1400);
		setall(`REG_OFF_SLOPE, 32'h1);
		setall(`REG_GAIN_ICPT, 32'h1000);
		for (int n = 0; n < 4; n++) begin
			wr(8'(`REG_OFF_ICPT + 4 * n), 32'(n + 1));
		end
		for (int k = 0; k < 5; k++) begin
			mcase(24'h0003E8, tc[k], ex[k], 3'b000);
		end
	endtask
	task automatic t_round();
		setall(`REG_OFF_SLOPE, 32'h0);
		setall(`REG_OFF_ICPT, 32'h0);
		setall(`REG_GAIN_ICPT, 32'h2000);
		mcase(24'h000003, 10'h000, 16'h0002, 3'b000);
		mcase(24'hFFFFFD, 10'h000, 16'hFFFE, 3'b000);
		mcase(24'h000005, 10'h000, 16'h0003, 3'b000);
		setall(`REG_GAIN_ICPT, 32'h0800);
		mcase(24'h000FA0, 10'h000, 16'h1F40, 3'b000);
		mcase(24'h004000, 10'h000, 16'h7FFF, 3'b100);
		mcase(24'hFFC000, 10'h000, 16'h8000, 3'b000);
		mcase(24'hFFBFFF, 10'h000, 16'h8000, 3'b100);
		setall(`REG_GAIN_SLOPE, 32'h200);
		mcase(24'h000123, 10'h100, 16'h0123, 3'b000);
		setall(`REG_GAIN_ICPT, 32'h07FF);
		samp(24'h000001, 1'b0, 10'h000);
		fl(3'b001, 3'b111);
	endtask
	task automatic t_errs();
		setall(`REG_GAIN_ICPT, 32'h1000);
		setall(`REG_OFF_ICPT, 32'h4000);
		samp(24'hFC0000, 1'b0, 10'h000);
		fl(3'b001, 3'b001);
		setall(`REG_OFF_ICPT, 32'h3FFF);
		mcase(24'hFC0000, 10'h000, 16'hFFF0, 3'b000);
		samp(24'h03FFFF, 1'b0, 10'h000);
		fl(3'b010, 3'b011);
	endtask
	task automatic t_second();
		lag <= 4'h6;
		wr(`REG_AUX_OFF, 32'h64);
		wr(`REG_AUX_GAIN, 32'h10000);
		scase(24'h000FA3, 16'h0384, 3'b000);
		wr(`REG_AUX_OFF, 32'h0);
		wr(`REG_AUX_GAIN, 32'h8000);
		scase(24'h000E14, 16'h01C3, 3'b000);
		scase(24'hFFF1EC, 16'hFE3D, 3'b000);
		wr(`REG_AUX_GAIN, 32'h1FFFF);
		scase(24'h013880, 16'h7FFF, 3'b100);
		scase(24'hFEC780, 16'h8000, 3'b100);
		wr(`REG_AUX_OFF, 32'h1FF9C);
		wr(`REG_AUX_GAIN, 32'h0);
		samp(24'h03FFFF, 1'b1, 10'h000);
		scase(24'h000400, 16'h0000, 3'b010);
		lag <= 4'h0;
	endtask
	////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		t_reset();
		t_gain();
		t_clamp();
		t_area();
		t_round();
		t_errs();
		t_second();
		t_reset();
		summarize();
	end

	// Watchdog against a hung handshake
	initial begin
		repeat (30000) @(posedge clk_sys);
		n_errors++;
		summarize();
	end
endmodule
`default_nettype wire
